/* File: testbench/windowed_watchdog_timer_test.sv */
// self-checking bench for the windowed watchdog top
`default_nettype none
module windowed_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, lso_tick, standby_mode, wdt_reset_req, irq;
  wwd_pkg::wwd_opt_s option_byte;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int fail_count = 0;
  int comparisons = 0;

  wwd_top dut (.aclk(aclk), .aresetn(aresetn), .lso_tick(lso_tick), .standby_mode(standby_mode),
    .option_byte(option_byte), .wdt_reset_req(wdt_reset_req), .irq(irq), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard: the longest overflow sweep needs about 16.5k cycles
  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    stop_test();
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic wwd_pkg::wwd_opt_s mk(logic au, logic sb, logic [2:0] sel, logic [1:0] w, logic ie);
    wwd_pkg::wwd_opt_s o;
    o.counter_autostart_option = au;
    o.standby_run_option = sb;
    o.overflow_time_select = sel;
    o.window_sel = wwd_pkg::wwd_win_e'(w);
    o.interval_irq_enable = ie;
    return o;
  endfunction

  // option byte is only captured at reset release, so each setup needs a fresh reset
  task automatic rst(input int cyc, input wwd_pkg::wwd_opt_s o);
    @(posedge aclk);
    aresetn <= 1'b0;
    option_byte <= o;
    lso_tick <= 1'b0;
    repeat (cyc) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  // n back-to-back oscillator ticks, one per cycle
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      lso_tick <= 1'b1;
    end
    @(posedge aclk);
    lso_tick <= 1'b0;
  endtask

  // ready is sampled at the falling edge: it only moves on rising edges, so it equals the next edge's value
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!tb && n < 100)
    begin
      @(negedge aclk);
      ta = s_awvalid & s_awready;
      tw = s_wvalid & s_wready;
      tb = s_bvalid === 1'b1;
      r = s_bresp;
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      n++;
    end
    s_bready <= 1'b0;
    chk("write answer", {31'h0, tb}, 32'h1);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!tr && n < 100)
    begin
      @(negedge aclk);
      ta = s_arvalid & s_arready;
      tr = s_rvalid === 1'b1;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
      if (ta) s_arvalid <= 1'b0;
      n++;
    end
    s_rready <= 1'b0;
    chk("read answer", {31'h0, tr}, 32'h1);
  endtask

  task automatic outs(input logic req, input logic ir);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("reset request", {31'h0, wdt_reset_req}, {31'h0, req});
    chk("irq", {31'h0, irq}, {31'h0, ir});
  endtask

  task automatic st_is(input logic [4:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(wwd_pkg::OFS_STATUS, d, r);
    chk("status", {27'h0, d[4:0]}, {27'h0, e});
    chk("status resp", {30'h0, r}, {30'h0, wwd_pkg::RESP_OKAY});
  endtask

  task automatic t_disabled;
    logic [1:0] r;
    logic [31:0] d;
    rst(2, mk(1'b0, 1'b0, 3'h0, 2'h3, 1'b0));
    ticks(200);
    outs(1'b0, 1'b0);
    axw(wwd_pkg::OFS_REFRESH, 32'h0000_0055, r);
    axw(wwd_pkg::OFS_BITOP, 32'h0000_00ac, r);
    outs(1'b0, 1'b0);
    axr(wwd_pkg::OFS_CONFIG, d, r);
    chk("run flag", {31'h0, d[8]}, 32'h0);
  endtask

  task automatic t_overflow;
    for (int s = 0; s < 8; s++)
    begin
      rst(2, mk(1'b1, 1'b0, s[2:0], 2'h3, 1'b0));
      ticks((1 << (6 + s)) - 1);
      outs(1'b0, 1'b0);
      ticks(1);
      outs(1'b1, 1'b0);
      st_is(5'h02);
    end
  endtask

  // window opens at count 48, 32, 16 for codes 0..2 with a 64-tick limit
  task automatic t_window;
    logic [1:0] r;
    int st;
    for (int w = 0; w < 3; w++)
    begin
      st = 48 - 16 * w;
      rst(2, mk(1'b1, 1'b0, 3'h0, w[1:0], 1'b0));
      ticks(st - 1);
      axw(wwd_pkg::OFS_REFRESH, 32'h0000_00ac, r);
      outs(1'b1, 1'b0);
      st_is(5'h10);
      rst(2, mk(1'b1, 1'b0, 3'h0, w[1:0], 1'b0));
      ticks(st);
      axw(wwd_pkg::OFS_REFRESH, 32'h0000_00ac, r);
      outs(1'b0, 1'b0);
      ticks(63);
      outs(1'b0, 1'b0);
      ticks(1);
      outs(1'b1, 1'b0);
    end
  endtask

  task automatic t_keys;
    logic [1:0] r;
    rst(2, mk(1'b1, 1'b0, 3'h0, 2'h3, 1'b0));
    axw(wwd_pkg::OFS_REFRESH, 32'h0000_0055, r);
    outs(1'b1, 1'b0);
    st_is(5'h04);
    rst(2, mk(1'b1, 1'b0, 3'h0, 2'h3, 1'b0));
    axw(wwd_pkg::OFS_BITOP, 32'h0000_00ac, r);
    outs(1'b1, 1'b0);
    st_is(5'h08);
  endtask

  task automatic t_standby;
    rst(2, mk(1'b1, 1'b0, 3'h0, 2'h3, 1'b0));
    standby_mode <= 1'b1;
    ticks(200);
    outs(1'b0, 1'b0);
    rst(2, mk(1'b1, 1'b1, 3'h0, 2'h3, 1'b0));
    ticks(64);
    outs(1'b1, 1'b0);
    standby_mode <= 1'b0;
  endtask

  task automatic t_interval;
    logic [1:0] r;
    rst(2, mk(1'b1, 1'b0, 3'h0, 2'h3, 1'b1));
    ticks(47);
    st_is(5'h00);
    axw(wwd_pkg::OFS_MASK, 32'h0000_0001, r);
    chk("mask write resp", {30'h0, r}, {30'h0, wwd_pkg::RESP_OKAY});
    outs(1'b0, 1'b0);
    ticks(1);
    st_is(5'h01);
    outs(1'b0, 1'b1);
    axw(wwd_pkg::OFS_MASK, 32'h0000_0000, r);
    outs(1'b0, 1'b0);
    axw(wwd_pkg::OFS_STATUS, 32'h0000_0001, r);
    outs(1'b0, 1'b0);
    st_is(5'h00);
  endtask

  task automatic t_unmapped;
    logic [1:0] r;
    logic [31:0] d;
    rst(2, mk(1'b1, 1'b0, 3'h5, 2'h3, 1'b0));
    axw(8'h14, 32'h0000_00ac, r);
    chk("unmapped write resp", {30'h0, r}, {30'h0, wwd_pkg::RESP_SLVERR});
    axr(8'h18, d, r);
    chk("unmapped read resp", {30'h0, r}, {30'h0, wwd_pkg::RESP_SLVERR});
    axr(wwd_pkg::OFS_CONFIG, d, r);
    chk("captured option", {24'h0, d[7:0]}, {24'h0, 8'h75});
    axr(wwd_pkg::OFS_REFRESH, d, r);
    chk("refresh word read", d, 32'h0000_0000);
    outs(1'b0, 1'b0);
  endtask

  initial
  begin
    aresetn = 1'b0;
    lso_tick = 1'b0;
    standby_mode = 1'b0;
    option_byte = wwd_pkg::OPT_RST;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    rst(12, mk(1'b0, 1'b0, 3'h0, 2'h3, 1'b0));
    t_disabled();
    t_overflow();
    t_window();
    t_keys();
    t_standby();
    t_interval();
    t_unmapped();
    stop_test();
  end
endmodule
`default_nettype wire

/* File: verilog/wwd_axil.sv */
// axi4-lite slave front end: write pulse out, read data in
`default_nettype none
module wwd_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_fire,
  output wwd_pkg::wwd_wr_s wr_req,
  input wire logic wr_err,
  output logic rd_fire,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  wwd_pkg::wwd_wr_s req_reg, req_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  // address and data may arrive in either order; write fires once both held
  always_comb
  begin
    s_awready = !aw_full_reg;
    s_wready = !w_full_reg;
    s_arready = !rvalid_reg;
    wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    rd_fire = s_arvalid && !rvalid_reg;
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    req_next = req_reg;
    bvalid_next = bvalid_reg && !s_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_awvalid && !aw_full_reg)
    begin
      aw_full_next = 1'b1;
      req_next.addr = s_awaddr;
    end
    if (s_wvalid && !w_full_reg)
    begin
      w_full_next = 1'b1;
      req_next.data = s_wdata;
      req_next.strb = s_wstrb;
    end
    if (wr_fire)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_err ? wwd_pkg::RESP_SLVERR : wwd_pkg::RESP_OKAY;
    end
    if (rd_fire)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_err ? wwd_pkg::RESP_SLVERR : wwd_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      req_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= wwd_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= wwd_pkg::RESP_OKAY;
      rdata_reg <= wwd_pkg::RDATA_RST;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      req_reg <= req_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wr_req = req_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;
endmodule
`default_nettype wire

/* File: verilog/wwd_counter.sv */
// watchdog up-counter with window and interval decode
`default_nettype none
module wwd_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] ovf_sel,
  input wire wwd_pkg::wwd_win_e win_sel,
  output logic [wwd_pkg::CNT_W-1:0] count,
  output logic win_open,
  output logic overflow,
  output logic interval
);
  logic [wwd_pkg::CNT_W-1:0] count_reg, count_next, limit, quarter, open_start;
  logic ovf_reg, ovf_next, int_reg, int_next;
  logic [3:0] shift_amt;

  always_comb
  begin
    shift_amt = {1'b0, ovf_sel} + wwd_pkg::OVF_BASE_SHIFT;
    limit = wwd_pkg::CNT_ONE << shift_amt;
    quarter = limit >> 2;
    unique case (win_sel)
      wwd_pkg::WIN_LAST_QUARTER: open_start = limit - quarter;
      wwd_pkg::WIN_LAST_HALF: open_start = limit - (quarter << 1);
      wwd_pkg::WIN_LAST_3QUARTER: open_start = quarter;
      wwd_pkg::WIN_ALWAYS: open_start = wwd_pkg::CNT_RST;
    endcase
    count_next = count_reg;
    ovf_next = 1'b0;
    int_next = 1'b0;
    if (clear)
    begin
      count_next = wwd_pkg::CNT_RST;
    end
    else if (run && tick)
    begin
      if (count_reg == limit - wwd_pkg::CNT_ONE)
      begin
        count_next = wwd_pkg::CNT_RST;
        ovf_next = 1'b1;
      end
      else
      begin
        count_next = count_reg + wwd_pkg::CNT_ONE;
        int_next = (count_next == limit - quarter);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= wwd_pkg::CNT_RST;
      ovf_reg <= 1'b0;
      int_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      int_reg <= int_next;
    end
  end

  assign count = count_reg;
  assign win_open = (count_reg >= open_start);
  assign overflow = ovf_reg;
  assign interval = int_reg;
endmodule
`default_nettype wire

/* File: verilog/wwd_pkg.sv */
// shared constants and types for the windowed watchdog
`default_nettype none
package wwd_pkg;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned EV_W = 5;
  localparam logic [3:0] OVF_BASE_SHIFT = 4'h6;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
  localparam logic [7:0] OFS_REFRESH = 8'h00;
  localparam logic [7:0] OFS_BITOP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] REFRESH_KEY = 8'hac;
  localparam int unsigned EV_INTERVAL = 0;
  localparam int unsigned EV_OVERFLOW = 1;
  localparam int unsigned EV_BAD_KEY = 2;
  localparam int unsigned EV_BIT_OP = 3;
  localparam int unsigned EV_CLOSED_WR = 4;
  localparam logic [EV_W-1:0] STATUS_RST = 5'h00;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    WIN_LAST_QUARTER = 2'b00,
    WIN_LAST_HALF = 2'b01,
    WIN_LAST_3QUARTER = 2'b10,
    WIN_ALWAYS = 2'b11
  } wwd_win_e;
  typedef struct packed {
    logic interval_irq_enable;
    wwd_win_e window_sel;
    logic [2:0] overflow_time_select;
    logic standby_run_option;
    logic counter_autostart_option;
  } wwd_opt_s;
  localparam wwd_opt_s OPT_RST = wwd_opt_s'(8'h00);
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wwd_wr_s;
endpackage
`default_nettype wire

/* File: verilog/wwd_top.sv */
// windowed watchdog timer top: option capture, refresh checks, status and interrupt
//
// The address map and the AXI4-Lite register port were decided locally.
`default_nettype none
module wwd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lso_tick,
  input wire logic standby_mode,
  input wire wwd_pkg::wwd_opt_s option_byte,
  output logic wdt_reset_req,
  output logic irq,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  logic wr_fire, wr_err, rd_fire, rd_err;
  wwd_pkg::wwd_wr_s wr_req;
  logic [31:0] rd_data;
  logic [wwd_pkg::CNT_W-1:0] count;
  logic win_open, overflow, interval;

  wwd_pkg::wwd_opt_s opt_reg, opt_next;
  logic strap_done_reg, strap_done_next;
  logic reset_req_reg, reset_req_next;
  logic [wwd_pkg::EV_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic [wwd_pkg::EV_W-1:0] events, w1c;
  logic enabled, run, refresh_wr, key_ok, valid_refresh;

  wwd_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_fire(wr_fire),
    .wr_req(wr_req),
    .wr_err(wr_err),
    .rd_fire(rd_fire),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  wwd_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(lso_tick),
    .run(run),
    .clear(valid_refresh),
    .ovf_sel(opt_reg.overflow_time_select),
    .win_sel(opt_reg.window_sel),
    .count(count),
    .win_open(win_open),
    .overflow(overflow),
    .interval(interval)
  );

  // option byte is a strap: caught on the first edge after reset release
  always_comb
  begin
    strap_done_next = 1'b1;
    opt_next = strap_done_reg ? opt_reg : option_byte;
  end

  // counting gate; an issued reset request freezes the count until chip reset
  always_comb
  begin
    enabled = strap_done_reg && opt_reg.counter_autostart_option;
    run = enabled && !reset_req_reg
      && (!standby_mode || opt_reg.standby_run_option);
  end

  // refresh checks; refresh and bit-op writes are ignored while the watchdog is disabled
  always_comb
  begin
    refresh_wr = wr_fire && (wr_req.addr == wwd_pkg::OFS_REFRESH) && enabled;
    key_ok = (wr_req.data[7:0] == wwd_pkg::REFRESH_KEY);
    valid_refresh = refresh_wr && key_ok && win_open && !reset_req_reg;
    events = '0;
    events[wwd_pkg::EV_INTERVAL] = interval && opt_reg.interval_irq_enable;
    events[wwd_pkg::EV_OVERFLOW] = overflow;
    events[wwd_pkg::EV_BAD_KEY] = refresh_wr && !key_ok;
    events[wwd_pkg::EV_BIT_OP] = wr_fire && (wr_req.addr == wwd_pkg::OFS_BITOP) && enabled;
    events[wwd_pkg::EV_CLOSED_WR] = refresh_wr && key_ok && !win_open;
  end

  // status is sticky; a new event in the clearing cycle wins over the clear
  always_comb
  begin
    w1c = '0;
    if (wr_fire && (wr_req.addr == wwd_pkg::OFS_STATUS) && wr_req.strb[0])
    begin
      w1c = wr_req.data[wwd_pkg::EV_W-1:0];
    end
    status_next = (status_reg & ~w1c) | events;
    mask_next = mask_reg;
    if (wr_fire && (wr_req.addr == wwd_pkg::OFS_MASK) && wr_req.strb[0])
    begin
      mask_next = wr_req.data[wwd_pkg::EV_W-1:0];
    end
    irq_next = |(status_next & mask_next);
    reset_req_next = reset_req_reg || (|events[wwd_pkg::EV_CLOSED_WR:wwd_pkg::EV_OVERFLOW]);
  end

  // decode: the refresh and bit-op words read zero, the count is never mapped
  always_comb
  begin
    wr_err = !(wr_req.addr == wwd_pkg::OFS_REFRESH || wr_req.addr == wwd_pkg::OFS_BITOP
      || wr_req.addr == wwd_pkg::OFS_STATUS || wr_req.addr == wwd_pkg::OFS_MASK
      || wr_req.addr == wwd_pkg::OFS_CONFIG);
    rd_err = 1'b0;
    rd_data = '0;
    unique case (s_araddr)
      wwd_pkg::OFS_REFRESH: rd_data = '0;
      wwd_pkg::OFS_BITOP: rd_data = '0;
      wwd_pkg::OFS_STATUS: rd_data = {27'h0000000, status_reg};
      wwd_pkg::OFS_MASK: rd_data = {27'h0000000, mask_reg};
      wwd_pkg::OFS_CONFIG: rd_data = {21'h000000, win_open, reset_req_reg, run, opt_reg};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opt_reg <= wwd_pkg::OPT_RST;
      strap_done_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      status_reg <= wwd_pkg::STATUS_RST;
      mask_reg <= wwd_pkg::MASK_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      opt_reg <= opt_next;
      strap_done_reg <= strap_done_next;
      reset_req_reg <= reset_req_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  assign wdt_reset_req = reset_req_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_autostart;
    $rose(strap_done_reg) && opt_reg.counter_autostart_option && !standby_mode
      && !reset_req_reg |-> run;
  endproperty
  a_autostart: assert property (p_autostart) else $error("counter not running after reset");

  property p_disabled_stays_zero;
    strap_done_reg && !opt_reg.counter_autostart_option |-> count == '0 && !wdt_reset_req;
  endproperty
  a_disabled_stays_zero: assert property (p_disabled_stays_zero) else $error("disabled counter moved");

  property p_standby_hold;
    standby_mode && !opt_reg.standby_run_option && lso_tick && !valid_refresh
      |=> count == $past(count);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("counter moved in standby");

  property p_standby_run;
    standby_mode && opt_reg.standby_run_option && enabled && !reset_req_reg && lso_tick
      && !valid_refresh |=> count != $past(count);
  endproperty
  a_standby_run: assert property (p_standby_run) else $error("counter stalled in standby");

  property p_overflow_reset;
    overflow |=> wdt_reset_req && status_reg[wwd_pkg::EV_OVERFLOW];
  endproperty
  a_overflow_reset: assert property (p_overflow_reset) else $error("overflow gave no reset");

  property p_bitop_reset;
    wr_fire && wr_req.addr == wwd_pkg::OFS_BITOP && enabled |=> wdt_reset_req && status_reg[wwd_pkg::EV_BIT_OP];
  endproperty
  a_bitop_reset: assert property (p_bitop_reset) else $error("bit write gave no reset");

  property p_bad_key;
    refresh_wr && wr_req.data[7:0] != wwd_pkg::REFRESH_KEY
      |=> wdt_reset_req && status_reg[wwd_pkg::EV_BAD_KEY];
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key gave no reset");

  property p_closed_write;
    refresh_wr && key_ok && !win_open |=> wdt_reset_req && status_reg[wwd_pkg::EV_CLOSED_WR];
  endproperty
  a_closed_write: assert property (p_closed_write) else $error("closed window write accepted");

  property p_window_full;
    opt_reg.window_sel == wwd_pkg::WIN_ALWAYS |-> win_open;
  endproperty
  a_window_full: assert property (p_window_full) else $error("window closed in always-open mode");

  property p_no_count_read;
    rd_fire && s_araddr == wwd_pkg::OFS_REFRESH |=> s_rvalid && s_rdata == 32'h0000_0000;
  endproperty
  a_no_count_read: assert property (p_no_count_read) else $error("refresh word read nonzero");

  property p_shortest_limit;
    run && lso_tick && opt_reg.overflow_time_select == 3'h0 && count == 14'h003f
      && !valid_refresh |=> overflow;
  endproperty
  a_shortest_limit: assert property (p_shortest_limit) else $error("shortest overflow missed");

  property p_refresh_clears;
    valid_refresh |=> count == '0 ##1 !overflow;
  endproperty
  a_refresh_clears: assert property (p_refresh_clears) else $error("refresh did not clear");

  property p_interval_irq;
    interval && opt_reg.interval_irq_enable && mask_reg[wwd_pkg::EV_INTERVAL] |=> irq;
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval interrupt missing");

  property p_reset_sticky;
    wdt_reset_req |=> wdt_reset_req;
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("reset request dropped");

  property p_frozen_after_req;
    wdt_reset_req |=> count == $past(count);
  endproperty
  a_frozen_after_req: assert property (p_frozen_after_req) else $error("counter moved after reset request");

  property p_overflow_flag_sticky;
    status_reg[wwd_pkg::EV_OVERFLOW] && !(wr_fire && wr_req.addr == wwd_pkg::OFS_STATUS)
      |=> status_reg[wwd_pkg::EV_OVERFLOW];
  endproperty
  a_overflow_flag_sticky: assert property (p_overflow_flag_sticky) else $error("overflow flag lost");

  property p_good_refresh_quiet;
    valid_refresh && !overflow
      |=> !wdt_reset_req;
  endproperty
  a_good_refresh_quiet: assert property (p_good_refresh_quiet) else $error("valid refresh raised reset");

  property p_window_starts_closed;
    count == '0 && opt_reg.window_sel != wwd_pkg::WIN_ALWAYS |-> !win_open;
  endproperty
  a_window_starts_closed: assert property (p_window_starts_closed) else $error("window open at cycle start");

  property p_awake_counts;
    !standby_mode && enabled && !reset_req_reg && lso_tick
      && !valid_refresh |=> count != $past(count);
  endproperty
  a_awake_counts: assert property (p_awake_counts) else $error("counter stalled while awake");

  property p_interval_flag;
    interval && opt_reg.interval_irq_enable |=> status_reg[wwd_pkg::EV_INTERVAL];
  endproperty
  a_interval_flag: assert property (p_interval_flag) else $error("interval flag not set");

  property p_irq_level;
    irq == (|(status_reg & mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level disagrees with masked status");

  c_refresh: cover property (valid_refresh ##1 count == '0);
  c_overflow: cover property (overflow ##1 wdt_reset_req);
  c_interval: cover property (interval ##1 irq);
  c_bad_key: cover property (events[wwd_pkg::EV_BAD_KEY]);
  c_closed_write: cover property (events[wwd_pkg::EV_CLOSED_WR]);
endmodule
`default_nettype wire
